//--- rtl/hbp_agent.sv
// Far end: a simple bus agent, initiator and memory target
`timescale 1ns/10ps
module hbp_agent
  import hbp_pkg::*;
#(
  parameter logic [31:0] BASE_ADDR = 32'hF000_0000,
  parameter logic [31:0] SIZE      = 32'h0000_1000
)(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  // User request
  input  wire logic        go_i,
  input  wire logic [3:0]  cmd_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [31:0] wdata_i,
  output logic             busy_o,
  output logic             done_o,
  output logic [31:0]      rdata_o,
  output logic             claimed_o,
  // Shared bus
  hbp_bus_if.agent         bus
);
  // ---------------------------------------------------------------
  // Single-phase initiator and local word target
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    HBP_A_IDLE = 2'b00,
    HBP_A_ADDR = 2'b01,
    HBP_A_DATA = 2'b10,
    HBP_A_TURN = 2'b11
  } hbp_agt_t;

  hbp_agt_t    st_q, st_d;
  logic [31:0] ad_q, ad_d, rd_q, rd_d, mem_q, mem_d;
  logic [3:0]  cmd_q, cmd_d, tcmd_q, tcmd_d;
  logic        done_q, done_d, cl_q, cl_d, par_q, tsel_q, tsel_d, fr_q;
  logic [2:0]  tmo_q, tmo_d;

  always_comb begin
    st_d = st_q;
    ad_d = ad_q;
    cmd_d = cmd_q;
    rd_d = rd_q;
    done_d = 1'b0;
    cl_d = cl_q;
    tmo_d = tmo_q;
    mem_d = mem_q;
    tsel_d = tsel_q;
    tcmd_d = tcmd_q;
    unique case (st_q)
      HBP_A_IDLE: begin
        if (go_i && hbp_cmd_ok(cmd_i) && bus.frame_n && bus.irdy_n) begin
          st_d = HBP_A_ADDR;
          ad_d = addr_i;
          cmd_d = cmd_i;
          tmo_d = 3'h0;
        end
      end
      HBP_A_ADDR: begin
        st_d = HBP_A_DATA;
        ad_d = wdata_i;
      end
      HBP_A_DATA: begin
        tmo_d = tmo_q + 3'h1;
        if (!bus.trdy_n || !bus.stop_n
            || (bus.devsel_n && tmo_q == 3'(HBP_DEVSEL_TMO))) begin
          st_d = HBP_A_TURN;
          done_d = 1'b1;
          cl_d = !bus.devsel_n;
          rd_d = bus.ad;
        end
      end
      HBP_A_TURN: st_d = HBP_A_IDLE;
      default: st_d = HBP_A_IDLE;
    endcase
    // Own word target: address phase claim, single phase
    if (!bus.frame_n && fr_q && st_q == HBP_A_IDLE) begin
      tsel_d = (bus.ad >= BASE_ADDR) && (bus.ad - BASE_ADDR < SIZE)
               && hbp_cmd_ok(bus.cbe_n);
      tcmd_d = bus.cbe_n;
    end else if (tsel_q && !bus.irdy_n) begin
      tsel_d = 1'b0;
      if (bus.cbe_n == 4'h0 && !hbp_is_rd(tcmd_q)) mem_d = bus.ad;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_q <= HBP_A_IDLE;
      ad_q <= 32'h0000_0000;
      cmd_q <= 4'h0;
      rd_q <= 32'h0000_0000;
      done_q <= 1'b0;
      cl_q <= 1'b0;
      tmo_q <= 3'h0;
      mem_q <= 32'h0000_0000;
      tsel_q <= 1'b0;
      tcmd_q <= 4'h0;
      fr_q <= 1'b1;
      par_q <= 1'b0;
    end else begin
      st_q <= st_d;
      ad_q <= ad_d;
      cmd_q <= cmd_d;
      rd_q <= rd_d;
      done_q <= done_d;
      cl_q <= cl_d;
      tmo_q <= tmo_d;
      mem_q <= mem_d;
      tsel_q <= tsel_d;
      tcmd_q <= tcmd_d;
      fr_q <= bus.frame_n;
      par_q <= hbp_par(ad_q, (st_q == HBP_A_IDLE) ? cmd_d : 4'h0);
    end
  end

  assign busy_o = (st_q != HBP_A_IDLE);
  assign done_o = done_q;
  assign rdata_o = rd_q;
  assign claimed_o = cl_q;
  // Single data phase, so frame drops with irdy rising
  assign bus.ag_mst_oe = (st_q != HBP_A_IDLE);
  assign bus.ag_frame_n_o = !(st_q == HBP_A_ADDR);
  assign bus.ag_irdy_n_o = !(st_q == HBP_A_DATA);
  assign bus.ag_lock_n_o = 1'b1;
  assign bus.ag_cbe_oe = (st_q == HBP_A_ADDR) || (st_q == HBP_A_DATA);
  assign bus.ag_cbe_n_o = (st_q == HBP_A_ADDR) ? cmd_q : 4'h0;
  assign bus.ag_ad_oe = (st_q == HBP_A_ADDR) || (st_q == HBP_A_DATA && !hbp_is_rd(cmd_q))
                        || (tsel_q && hbp_is_rd(tcmd_q));
  assign bus.ag_ad_o = tsel_q ? mem_q : ad_q;
  assign bus.ag_par_oe = 1'b0;
  assign bus.ag_par_o = par_q;
  assign bus.ag_tgt_oe = tsel_q;
  assign bus.ag_devsel_n_o = !tsel_q;
  assign bus.ag_trdy_n_o = !tsel_q;
  assign bus.ag_stop_n_o = 1'b1;
endmodule

//--- rtl/hbp_bridge.sv
// Bridge end: initiator for processor cycles, target for memory ranges
`timescale 1ns/10ps
module hbp_bridge
  import hbp_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  // Processor request
  input  wire logic        req_valid_i,
  output logic             req_ready_o,
  input  wire logic [3:0]  req_cmd_i,
  input  wire logic [31:0] req_addr_i,
  input  wire logic [31:0] req_wdata_i,
  input  wire logic [3:0]  req_be_n_i,
  input  wire logic        req_last_i,
  input  wire logic        req_lock_i,
  // Processor answer
  output logic             rsp_valid_o,
  output logic [31:0]      rsp_rdata_o,
  output logic [1:0]       rsp_status_o,
  // Decode windows
  input  wire logic [31:0] dram_top_i,
  input  wire logic [31:0] aper_base_i,
  input  wire logic [31:0] aper_size_i,
  // Memory side for target accesses
  output logic             mem_wr_o,
  output logic             mem_rd_o,
  output logic [31:0]      mem_addr_o,
  output logic [31:0]      mem_wdata_o,
  output logic [3:0]       mem_be_n_o,
  input  wire logic [31:0] mem_rdata_i,
  // Shared bus
  hbp_bus_if.bridge        bus
);
  // ---------------------------------------------------------------
  // Initiator
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    HBP_M_IDLE = 3'b000,
    HBP_M_ADDR = 3'b001,
    HBP_M_DATA = 3'b010,
    HBP_M_TURN = 3'b011
  } hbp_mst_t;

  hbp_mst_t    m_st_q, m_st_d;
  logic [31:0] m_ad_q, m_ad_d;
  logic [3:0]  m_cbe_q, m_cbe_d, m_cmd_q, m_cmd_d;
  logic        m_frame_q, m_frame_d;
  logic        m_par_q, m_par_d, m_paroe_q, m_paroe_d;
  logic        m_lock_q, m_lock_d;
  logic [2:0]  m_tmo_q, m_tmo_d;
  logic        r_v_q, r_v_d;
  logic [31:0] r_dat_q, r_dat_d;
  logic [1:0]  r_st_q, r_st_d;
  logic        m_done;

  assign m_done = !bus.irdy_n && (!bus.trdy_n || !bus.stop_n);
  assign req_ready_o = (m_st_q == HBP_M_IDLE) && hbp_cmd_ok(req_cmd_i)
                       && bus.frame_n && bus.irdy_n
                       || (m_st_q == HBP_M_DATA) && !bus.trdy_n && !bus.irdy_n
                          && m_frame_q;

  always_comb begin
    m_st_d = m_st_q;
    m_ad_d = m_ad_q;
    m_cbe_d = m_cbe_q;
    m_cmd_d = m_cmd_q;
    m_frame_d = m_frame_q;
    m_par_d = hbp_par(m_ad_q, m_cbe_q);
    m_paroe_d = (m_st_q != HBP_M_IDLE) && (m_st_q != HBP_M_TURN)
                && (m_st_q == HBP_M_ADDR || !hbp_is_rd(m_cmd_q));
    m_lock_d = m_lock_q;
    m_tmo_d = m_tmo_q;
    r_v_d = 1'b0;
    r_dat_d = r_dat_q;
    r_st_d = r_st_q;
    unique case (m_st_q)
      HBP_M_IDLE: begin
        // Reserved codes are held off and never reach the bus
        if (req_valid_i && hbp_cmd_ok(req_cmd_i) && bus.frame_n && bus.irdy_n) begin
          m_st_d = HBP_M_ADDR;
          m_ad_d = req_addr_i;
          m_cbe_d = req_cmd_i;
          m_cmd_d = req_cmd_i;
          m_frame_d = 1'b1;
          m_lock_d = req_lock_i;
          m_tmo_d = 3'h0;
        end
      end
      HBP_M_ADDR: begin
        m_st_d = HBP_M_DATA;
        m_ad_d = req_wdata_i;
        m_cbe_d = req_be_n_i;
        m_frame_d = !req_last_i;
      end
      HBP_M_DATA: begin
        m_tmo_d = m_tmo_q + 3'h1;
        if (bus.devsel_n && m_tmo_q == 3'(HBP_DEVSEL_TMO)) begin
          m_st_d = HBP_M_TURN;
          m_frame_d = 1'b0;
          r_v_d = 1'b1;
          r_st_d = 2'h3;
        end else if (m_done) begin
          r_v_d = 1'b1;
          r_dat_d = bus.ad;
          r_st_d = !bus.trdy_n ? 2'h0 : (bus.devsel_n ? 2'h2 : 2'h1);
          if (!m_frame_q || bus.trdy_n) begin
            m_st_d = HBP_M_TURN;
            m_frame_d = 1'b0;
          end else begin
            m_ad_d = req_wdata_i;
            m_cbe_d = req_be_n_i;
            m_frame_d = !req_last_i;
          end
        end else if (!bus.stop_n && m_frame_q) begin
          m_frame_d = 1'b0;
        end
      end
      HBP_M_TURN: begin
        m_st_d = HBP_M_IDLE;
        if (r_st_q != 2'h0) m_lock_d = 1'b0;
        if (m_cmd_q == HBP_CMD_SPEC) m_lock_d = m_lock_q;
      end
      default: m_st_d = HBP_M_IDLE;
    endcase
    if (!req_lock_i && m_st_q == HBP_M_IDLE) m_lock_d = 1'b0;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      m_st_q <= HBP_M_IDLE;
      m_ad_q <= 32'h0000_0000;
      m_cbe_q <= 4'hF;
      m_cmd_q <= 4'h0;
      m_frame_q <= 1'b0;
      m_par_q <= 1'b0;
      m_paroe_q <= 1'b0;
      m_lock_q <= 1'b0;
      m_tmo_q <= 3'h0;
      r_v_q <= 1'b0;
      r_dat_q <= 32'h0000_0000;
      r_st_q <= 2'h0;
    end else begin
      m_st_q <= m_st_d;
      m_ad_q <= m_ad_d;
      m_cbe_q <= m_cbe_d;
      m_cmd_q <= m_cmd_d;
      m_frame_q <= m_frame_d;
      m_par_q <= m_par_d;
      m_paroe_q <= m_paroe_d;
      m_lock_q <= m_lock_d;
      m_tmo_q <= m_tmo_d;
      r_v_q <= r_v_d;
      r_dat_q <= r_dat_d;
      r_st_q <= r_st_d;
    end
  end

  assign rsp_valid_o = r_v_q;
  assign rsp_rdata_o = r_dat_q;
  assign rsp_status_o = r_st_q;

  // ---------------------------------------------------------------
  // Target
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    HBP_T_IDLE = 2'b00,
    HBP_T_DATA = 2'b01,
    HBP_T_BUSY = 2'b10,
    HBP_T_TURN = 2'b11
  } hbp_tgt_t;

  hbp_tgt_t    t_st_q, t_st_d;
  logic [31:0] t_addr_q, t_addr_d, t_rd_q, t_rd_d;
  logic [3:0]  t_cmd_q, t_cmd_d;
  logic        t_frame_q, t_tpar_q, t_tpar_d, t_paroe_q, t_paroe_d;
  logic        t_hit, t_mem, t_xfer;

  // Own initiator's frame must not look like a foreign address phase
  assign t_mem = (t_cmd_q == HBP_CMD_MEMRD) || (t_cmd_q == HBP_CMD_MEMWR)
                 || hbp_is_mrd(t_cmd_q) || (t_cmd_q == HBP_CMD_MWINV);
  assign t_hit = (bus.ad < dram_top_i)
                 || (bus.ad >= aper_base_i && bus.ad - aper_base_i < aper_size_i);
  assign t_xfer = (t_st_q == HBP_T_DATA) && !bus.irdy_n;

  always_comb begin
    t_st_d = t_st_q;
    t_addr_d = t_addr_q;
    t_cmd_d = t_cmd_q;
    t_rd_d = t_rd_q;
    t_tpar_d = hbp_par(t_rd_q, bus.cbe_n);
    t_paroe_d = (t_st_q == HBP_T_DATA) && hbp_is_mrd(t_cmd_q);
    unique case (t_st_q)
      HBP_T_IDLE: begin
        // Sample on the first edge that sees frame fall
        if (!bus.frame_n && t_frame_q && m_st_q == HBP_M_IDLE) begin
          t_addr_d = bus.ad;
          t_cmd_d = bus.cbe_n;
          // Foreign locked sequences and reserved codes are not claimed
          if (t_hit && hbp_cmd_ok(bus.cbe_n) && bus.lock_n) begin
            t_st_d = HBP_T_DATA;
            t_rd_d = mem_rdata_i;
          end else begin
            t_st_d = HBP_T_BUSY;
          end
        end
      end
      HBP_T_DATA: begin
        if (t_xfer) begin
          t_addr_d = t_addr_q + 32'h4;
          t_rd_d = mem_rdata_i;
          if (bus.frame_n) t_st_d = HBP_T_TURN;
        end
      end
      HBP_T_BUSY: begin
        if (bus.frame_n && bus.irdy_n) t_st_d = HBP_T_IDLE;
      end
      HBP_T_TURN: t_st_d = HBP_T_IDLE;
      default: t_st_d = HBP_T_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      t_st_q <= HBP_T_IDLE;
      t_addr_q <= 32'h0000_0000;
      t_cmd_q <= 4'h0;
      t_rd_q <= 32'h0000_0000;
      t_frame_q <= 1'b1;
      t_tpar_q <= 1'b0;
      t_paroe_q <= 1'b0;
    end else begin
      t_st_q <= t_st_d;
      t_addr_q <= t_addr_d;
      t_cmd_q <= t_cmd_d;
      t_rd_q <= t_rd_d;
      t_frame_q <= bus.frame_n;
      t_tpar_q <= t_tpar_d;
      t_paroe_q <= t_paroe_d;
    end
  end

  assign mem_addr_o = t_addr_q;
  assign mem_wdata_o = bus.ad;
  assign mem_be_n_o = bus.cbe_n;
  assign mem_wr_o = t_xfer && !hbp_is_rd(t_cmd_q) && t_mem;
  assign mem_rd_o = t_xfer && hbp_is_rd(t_cmd_q) && t_mem;

  // ---------------------------------------------------------------
  // Pin drive
  // ---------------------------------------------------------------
  assign bus.br_mst_oe = (m_st_q != HBP_M_IDLE);
  assign bus.br_frame_n_o = !m_frame_q;
  assign bus.br_irdy_n_o = !(m_st_q == HBP_M_DATA);
  assign bus.br_lock_n_o = !m_lock_q;
  assign bus.br_tgt_oe = (t_st_q == HBP_T_DATA) || (t_st_q == HBP_T_TURN);
  assign bus.br_devsel_n_o = !(t_st_q == HBP_T_DATA);
  assign bus.br_trdy_n_o = !(t_st_q == HBP_T_DATA);
  assign bus.br_stop_n_o = !((t_st_q == HBP_T_DATA) && !t_mem);
  assign bus.br_cbe_oe = (m_st_q == HBP_M_ADDR) || (m_st_q == HBP_M_DATA);
  assign bus.br_cbe_n_o = m_cbe_q;
  // Write data and address from initiator, read data from target
  assign bus.br_ad_oe = (m_st_q == HBP_M_ADDR)
                        || (m_st_q == HBP_M_DATA && !hbp_is_rd(m_cmd_q))
                        || (t_st_q == HBP_T_DATA && hbp_is_rd(t_cmd_q));
  assign bus.br_ad_o = (t_st_q == HBP_T_DATA) ? t_rd_q : m_ad_q;
  assign bus.br_par_oe = m_paroe_q || t_paroe_q;
  assign bus.br_par_o = t_paroe_q ? t_tpar_q : m_par_q;
endmodule

//--- rtl/hbp_bus_if.sv
// Interface: shared primary bus wires, one modport per party
`timescale 1ns/10ps
interface hbp_bus_if;
  // Bridge side drive and enables
  logic [31:0] br_ad_o;
  logic        br_ad_oe;
  logic [3:0]  br_cbe_n_o;
  logic        br_cbe_oe;
  logic        br_par_o;
  logic        br_par_oe;
  logic        br_frame_n_o;
  logic        br_irdy_n_o;
  logic        br_mst_oe;
  logic        br_lock_n_o;
  logic        br_devsel_n_o;
  logic        br_trdy_n_o;
  logic        br_stop_n_o;
  logic        br_tgt_oe;
  // Far agent drive and enables
  logic [31:0] ag_ad_o;
  logic        ag_ad_oe;
  logic [3:0]  ag_cbe_n_o;
  logic        ag_cbe_oe;
  logic        ag_par_o;
  logic        ag_par_oe;
  logic        ag_frame_n_o;
  logic        ag_irdy_n_o;
  logic        ag_mst_oe;
  logic        ag_lock_n_o;
  logic        ag_devsel_n_o;
  logic        ag_trdy_n_o;
  logic        ag_stop_n_o;
  logic        ag_tgt_oe;
  // Resolved wire levels, pulled up when nobody drives
  logic [31:0] ad;
  logic [3:0]  cbe_n;
  logic        par;
  logic        frame_n;
  logic        irdy_n;
  logic        lock_n;
  logic        devsel_n;
  logic        trdy_n;
  logic        stop_n;

  assign ad       = br_ad_oe ? br_ad_o : (ag_ad_oe ? ag_ad_o : 32'hFFFF_FFFF);
  assign cbe_n    = br_cbe_oe ? br_cbe_n_o : (ag_cbe_oe ? ag_cbe_n_o : 4'hF);
  assign par      = br_par_oe ? br_par_o : (ag_par_oe ? ag_par_o : 1'b1);
  assign frame_n  = br_mst_oe ? br_frame_n_o : (ag_mst_oe ? ag_frame_n_o : 1'b1);
  assign irdy_n   = br_mst_oe ? br_irdy_n_o : (ag_mst_oe ? ag_irdy_n_o : 1'b1);
  assign lock_n   = br_mst_oe ? br_lock_n_o : (ag_mst_oe ? ag_lock_n_o : 1'b1);
  assign devsel_n = br_tgt_oe ? br_devsel_n_o : (ag_tgt_oe ? ag_devsel_n_o : 1'b1);
  assign trdy_n   = br_tgt_oe ? br_trdy_n_o : (ag_tgt_oe ? ag_trdy_n_o : 1'b1);
  assign stop_n   = br_tgt_oe ? br_stop_n_o : (ag_tgt_oe ? ag_stop_n_o : 1'b1);

  modport bridge (
    output br_ad_o, br_ad_oe, br_cbe_n_o, br_cbe_oe, br_par_o, br_par_oe,
    output br_frame_n_o, br_irdy_n_o, br_mst_oe, br_lock_n_o,
    output br_devsel_n_o, br_trdy_n_o, br_stop_n_o, br_tgt_oe,
    input  ad, cbe_n, par, frame_n, irdy_n, lock_n, devsel_n, trdy_n, stop_n
  );
  modport agent (
    output ag_ad_o, ag_ad_oe, ag_cbe_n_o, ag_cbe_oe, ag_par_o, ag_par_oe,
    output ag_frame_n_o, ag_irdy_n_o, ag_mst_oe, ag_lock_n_o,
    output ag_devsel_n_o, ag_trdy_n_o, ag_stop_n_o, ag_tgt_oe,
    input  ad, cbe_n, par, frame_n, irdy_n, lock_n, devsel_n, trdy_n, stop_n
  );
endinterface

//--- rtl/hbp_pkg.sv
// Package: shared constants for the primary bus port and its far end
// Function
// - Initiator drives address with frame, then data
// - Target takes address first, data afterwards
// - Claim only main memory or aperture ranges
// - Initiator samples device select for claim
// - Frame held until last data phase
// - Target latches command and address on frame
// - Initiator ready driven as initiator, sampled target
// - Command in address, byte enables in data
// - Interrupt acknowledge 0000, special cycle 0001
// - I/O read 0010, I/O write 0011
// - Memory read 0110, memory write 0111
// - Config read 1010, config write 1011
// - Memory read multiple is 1100
// - Read line 1110, write invalidate 1111
// - Reserved codes never issued nor supported
// - Even parity over data and command lines; agent never drives it, bridge target only for memory reads
// - Phase completes when both readies asserted
// - Stop signals disconnect, retry or abort
// - Lock honoured only for processor cycles
package hbp_pkg;
  // ---------------------------------------------------------------
  // Bus commands
  // ---------------------------------------------------------------
  localparam logic [3:0] HBP_CMD_INTA  = 4'h0;
  localparam logic [3:0] HBP_CMD_SPEC  = 4'h1;
  localparam logic [3:0] HBP_CMD_IORD  = 4'h2;
  localparam logic [3:0] HBP_CMD_IOWR  = 4'h3;
  localparam logic [3:0] HBP_CMD_MEMRD = 4'h6;
  localparam logic [3:0] HBP_CMD_MEMWR = 4'h7;
  localparam logic [3:0] HBP_CMD_CFGRD = 4'hA;
  localparam logic [3:0] HBP_CMD_CFGWR = 4'hB;
  localparam logic [3:0] HBP_CMD_MRMUL = 4'hC;
  localparam logic [3:0] HBP_CMD_DUAL  = 4'hD;
  localparam logic [3:0] HBP_CMD_MRLN  = 4'hE;
  localparam logic [3:0] HBP_CMD_MWINV = 4'hF;
  // ---------------------------------------------------------------
  // Decode defaults and timing
  // ---------------------------------------------------------------
  localparam logic [31:0] HBP_DRAM_TOP_RST = 32'h0400_0000;
  localparam logic [31:0] HBP_APER_BASE_RST = 32'hE000_0000;
  localparam logic [31:0] HBP_APER_SIZE_RST = 32'h0400_0000;
  localparam int unsigned HBP_DEVSEL_TMO = 5; // Cycles to wait for a claim

  // Legal command check used by both ends
  function automatic logic hbp_cmd_ok(input logic [3:0] c);
    hbp_cmd_ok = !(c == 4'h4 || c == 4'h5 || c == 4'h8 || c == 4'h9
                   || c == HBP_CMD_DUAL);
  endfunction

  // Even parity over data and command
  function automatic logic hbp_par(input logic [31:0] ad, input logic [3:0] cbe);
    hbp_par = ^{ad, cbe};
  endfunction

  // Memory read family carries target parity
  function automatic logic hbp_is_mrd(input logic [3:0] c);
    hbp_is_mrd = (c == HBP_CMD_MEMRD) || (c == HBP_CMD_MRMUL) || (c == HBP_CMD_MRLN);
  endfunction

  function automatic logic hbp_is_rd(input logic [3:0] c);
    hbp_is_rd = !c[0];
  endfunction
endpackage

//--- tb/hbp_props.sv
// Checker: protocol properties on the bus between bridge and agent
`timescale 1ns/10ps
module hbp_props
  import hbp_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  // Resolved bus
  input  wire logic [31:0] ad,
  input  wire logic [3:0]  cbe_n,
  input  wire logic        frame_n,
  input  wire logic        irdy_n,
  input  wire logic        devsel_n,
  input  wire logic        trdy_n,
  input  wire logic        stop_n,
  input  wire logic        par,
  // Drive enables
  input  wire logic        br_mst_oe,
  input  wire logic        br_tgt_oe,
  input  wire logic        br_ad_oe,
  input  wire logic        br_par_oe,
  input  wire logic        ag_mst_oe
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  // Out of both windows, using the decode values the bench applies
  wire out_win = (ad >= HBP_DRAM_TOP_RST)
                 && !(ad >= HBP_APER_BASE_RST && ad < HBP_APER_BASE_RST + HBP_APER_SIZE_RST);
  property p_rst_idle;
    !$past(resetn_i) |-> !br_mst_oe && !br_tgt_oe && !br_ad_oe;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("bus driven after reset");
  property p_no_rsvd;
    br_mst_oe && $fell(frame_n) |-> hbp_cmd_ok(cbe_n);
  endproperty
  a_no_rsvd: assert property (p_no_rsvd) else $error("reserved command issued");
  property p_addr_drv;
    br_mst_oe && $fell(frame_n) |-> br_ad_oe ##1 !irdy_n;
  endproperty
  a_addr_drv: assert property (p_addr_drv) else $error("address phase malformed");
  property p_last;
    br_mst_oe && $rose(frame_n) |-> !irdy_n;
  endproperty
  a_last: assert property (p_last) else $error("frame ended without ready");
  property p_done_rel;
    !irdy_n && (!trdy_n || !stop_n) && frame_n |=> irdy_n;
  endproperty
  a_done_rel: assert property (p_done_rel) else $error("ready held after last");
  property p_tgt_claim;
    ag_mst_oe && $fell(frame_n) ##1 br_tgt_oe |-> !devsel_n && !trdy_n;
  endproperty
  a_tgt_claim: assert property (p_tgt_claim) else $error("claim timing wrong");
  property p_mem_nostop;
    ag_mst_oe && $fell(frame_n) && hbp_is_mrd(cbe_n) ##1 br_tgt_oe |-> stop_n;
  endproperty
  a_mem_nostop: assert property (p_mem_nostop) else $error("memory read stopped");
  property p_no_claim;
    ag_mst_oe && $fell(frame_n) && out_win |=> !br_tgt_oe [*2];
  endproperty
  a_no_claim: assert property (p_no_claim) else $error("claimed outside windows");
  property p_par;
    br_par_oe |-> par == (^{$past(ad), $past(cbe_n)});
  endproperty
  a_par: assert property (p_par) else $error("parity wrong");
  // ---------------------------------------------------------------
  // Covers
  // ---------------------------------------------------------------
  c_br_mst: cover property (br_mst_oe && $rose(frame_n));
  c_br_tgt: cover property (br_tgt_oe && !devsel_n);
  c_no_claim: cover property (ag_mst_oe && $fell(frame_n) && out_win);
endmodule

//--- tb/host_bridge_pci_primary_port_bench.sv
// Bench: bridge and agent on one bus, driven from their user sides
`timescale 1ns/10ps
module host_bridge_pci_primary_port_bench
  import hbp_pkg::*;
;
  // ---------------------------------------------------------------
  // Stimulus and observation
  // ---------------------------------------------------------------
  localparam logic [31:0] AG_BASE = 32'hF000_0000;
  logic        clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic        req_valid_i = 1'b0;
  logic        req_ready_o, rsp_valid_o, mem_wr_o, mem_rd_o;
  logic [3:0]  req_cmd_i = 4'h0;
  logic [3:0]  req_be_n_i = 4'h0;
  logic [31:0] req_addr_i = 32'h0;
  logic [31:0] req_wdata_i = 32'h0;
  logic [31:0] mem_rdata_i = 32'h0;
  logic [31:0] rsp_rdata_o, mem_addr_o, mem_wdata_o, rdata_o;
  logic [1:0]  rsp_status_o;
  logic [3:0]  mem_be_n_o;
  logic        go_i = 1'b0;
  logic [3:0]  cmd_i = 4'h0;
  logic [31:0] addr_i = 32'h0;
  logic [31:0] wdata_i = 32'h0;
  logic        busy_o, done_o, claimed_o;
  int          n_errors = 0;
  int          checks_done = 0;
  int          n_wr = 0;
  int          n_rd = 0;
  logic [31:0] wr_addr, wr_data;
  always #10 clk_i = ~clk_i;
  hbp_bus_if hbp_bus_if_inst ();
  wire bus_busy = hbp_bus_if_inst.br_mst_oe | hbp_bus_if_inst.ag_mst_oe
                  | hbp_bus_if_inst.br_tgt_oe | hbp_bus_if_inst.ag_tgt_oe;
  hbp_bridge hbp_bridge_inst (
    .clk_i(clk_i), .resetn_i(resetn_i), .req_valid_i(req_valid_i),
    .req_ready_o(req_ready_o), .req_cmd_i(req_cmd_i), .req_addr_i(req_addr_i),
    .req_wdata_i(req_wdata_i), .req_be_n_i(req_be_n_i), .req_last_i(1'b1),
    .req_lock_i(1'b0), .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o),
    .rsp_status_o(rsp_status_o), .dram_top_i(HBP_DRAM_TOP_RST),
    .aper_base_i(HBP_APER_BASE_RST), .aper_size_i(HBP_APER_SIZE_RST),
    .mem_wr_o(mem_wr_o), .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o), .mem_be_n_o(mem_be_n_o), .mem_rdata_i(mem_rdata_i),
    .bus(hbp_bus_if_inst)
  );
  hbp_agent #(.BASE_ADDR(AG_BASE), .SIZE(32'h0000_1000)) hbp_agent_inst (
    .clk_i(clk_i), .resetn_i(resetn_i), .go_i(go_i), .cmd_i(cmd_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .busy_o(busy_o), .done_o(done_o), .rdata_o(rdata_o),
    .claimed_o(claimed_o), .bus(hbp_bus_if_inst)
  );
  hbp_props hbp_props_inst (
    .clk_i(clk_i), .resetn_i(resetn_i), .ad(hbp_bus_if_inst.ad),
    .cbe_n(hbp_bus_if_inst.cbe_n), .frame_n(hbp_bus_if_inst.frame_n),
    .irdy_n(hbp_bus_if_inst.irdy_n), .devsel_n(hbp_bus_if_inst.devsel_n),
    .trdy_n(hbp_bus_if_inst.trdy_n), .stop_n(hbp_bus_if_inst.stop_n),
    .br_mst_oe(hbp_bus_if_inst.br_mst_oe), .br_tgt_oe(hbp_bus_if_inst.br_tgt_oe),
    .par(hbp_bus_if_inst.par), .br_par_oe(hbp_bus_if_inst.br_par_oe),
    .br_ad_oe(hbp_bus_if_inst.br_ad_oe), .ag_mst_oe(hbp_bus_if_inst.ag_mst_oe)
  );
  // Memory side monitor, sampled before the edge updates land
  always @(posedge clk_i) begin
    if (mem_wr_o === 1'b1) begin
      n_wr <= n_wr + 1;
      wr_addr <= mem_addr_o;
      wr_data <= mem_wdata_o;
    end
    if (mem_rd_o === 1'b1) begin
      n_rd <= n_rd + 1;
    end
  end
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // No arbiter here, so one party waits until the bus is fully released
  task automatic bus_idle;
    int k;
    k = 0;
    while (bus_busy !== 1'b0 && k < 20) begin
      @(negedge clk_i);
      k++;
    end
    @(negedge clk_i);
  endtask
  task automatic br_op(input logic [3:0] c, input logic [31:0] a, input logic [31:0] d);
    int k;
    bus_idle();
    req_cmd_i = c;
    req_addr_i = a;
    req_wdata_i = d;
    req_valid_i = 1'b1;
    k = 0;
    while (req_ready_o !== 1'b1 && k < 20) begin
      @(negedge clk_i);
      k++;
    end
    @(negedge clk_i);
    req_valid_i = 1'b0;
    while (rsp_valid_o !== 1'b1 && k < 40) begin
      @(negedge clk_i);
      k++;
    end
  endtask
  task automatic ag_op(input logic [3:0] c, input logic [31:0] a, input logic [31:0] d);
    int k;
    bus_idle();
    cmd_i = c;
    addr_i = a;
    wdata_i = d;
    go_i = 1'b1;
    @(negedge clk_i);
    go_i = 1'b0;
    k = 0;
    while (done_o !== 1'b1 && k < 40) begin
      @(negedge clk_i);
      k++;
    end
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  logic [3:0]  rsv [5] = '{4'h4, 4'h5, 4'h8, 4'h9, HBP_CMD_DUAL};
  logic [3:0]  wcmd [2] = '{HBP_CMD_MEMWR, HBP_CMD_MWINV};
  logic [31:0] wadr [2] = '{32'h0000_0100, HBP_DRAM_TOP_RST - 32'h4};
  logic [3:0]  rcmd [3] = '{HBP_CMD_MEMRD, HBP_CMD_MRMUL, HBP_CMD_MRLN};
  logic [31:0] radr [3] = '{32'h0000_0200, HBP_APER_BASE_RST + 32'h80, 32'h0000_0000};
  initial begin
    repeat (16) @(negedge clk_i);
    resetn_i = 1'b1;
    br_op(HBP_CMD_MEMWR, AG_BASE, 32'h1234_ABCD);
    check("write status", rsp_status_o, 32'h0);
    br_op(HBP_CMD_MEMRD, AG_BASE, 32'h0);
    check("read data", rsp_rdata_o, 32'h1234_ABCD);
    br_op(HBP_CMD_MEMRD, 32'h8000_0000, 32'h0);
    check("no claim status", rsp_status_o, 32'h3);
    $display("test bridge initiator done");
    foreach (rsv[i]) begin
      req_cmd_i = rsv[i];
      req_valid_i = 1'b1;
      repeat (3) @(negedge clk_i);
      check("reserved ready", req_ready_o, 32'h0);
      req_valid_i = 1'b0;
    end
    $display("test reserved codes done");
    foreach (wcmd[i]) begin
      ag_op(wcmd[i], wadr[i], 32'hC0DE_0000 + i);
      check("write claimed", claimed_o, 32'h1);
      check("mem addr", wr_addr, wadr[i]);
      check("mem data", wr_data, 32'hC0DE_0000 + i);
      check("mem writes", n_wr, i + 1);
    end
    foreach (rcmd[i]) begin
      mem_rdata_i = 32'h5A00_0000 + i;
      ag_op(rcmd[i], radr[i], 32'h0);
      check("target rdata", rdata_o, 32'h5A00_0000 + i);
      check("read claimed", claimed_o, 32'h1);
      check("mem reads", n_rd, i + 1);
    end
    ag_op(HBP_CMD_MEMRD, HBP_DRAM_TOP_RST, 32'h0);
    check("outside claimed", claimed_o, 32'h0);
    ag_op(HBP_CMD_IOWR, 32'h0000_0100, 32'h0);
    check("io no mem write", n_wr, 32'h2);
    $display("test bridge target done");
    conclude();
  end
  initial begin
    #(20 * 5000);
    n_errors++;
    conclude();
  end
endmodule
